/* File: rtl/dsp_device_end.sv */
// Device end: two full-duplex serial ports, receive buffering, loader path
// Behaviour
// - Two independent full-duplex serial ports
// - Eight data bits, no parity, one stop
// - Per-port baud rate, 300 to 600K
// - Start bit low, stop bit high
// - Data bits sent least significant first
// - Single-byte or background buffered receive
// - Port zero carries download until application runs
// - Reset pin low over 2 us resets
// - Device never drives its reset pin
module dsp_device_end
  import dsp_pkg::*;
(
  input  wire logic                                           core_clk_i,
  input  wire logic                                           rst_i,
  dsp_link_if.dev                                             link,
  input  wire logic [dsp_pkg::NUM_PORTS-1:0][dsp_pkg::DIV_W-1:0] baud_div_i,
  input  wire logic [dsp_pkg::NUM_PORTS-1:0]                  buffered_mode_i,
  input  wire logic [dsp_pkg::NUM_PORTS-1:0]                  tx_valid_i,
  input  wire logic [dsp_pkg::NUM_PORTS-1:0][7:0]             tx_data_i,
  output logic      [dsp_pkg::NUM_PORTS-1:0]                  tx_ready_o,
  output logic      [dsp_pkg::NUM_PORTS-1:0]                  rx_valid_o,
  output logic      [dsp_pkg::NUM_PORTS-1:0][7:0]             rx_data_o,
  input  wire logic [dsp_pkg::NUM_PORTS-1:0]                  rx_ready_i,
  output logic      [dsp_pkg::NUM_PORTS-1:0]                  rx_overrun_o,
  output logic      [dsp_pkg::NUM_PORTS-1:0]                  rx_frame_err_o,
  input  wire logic [dsp_pkg::NUM_PORTS-1:0]                  err_clear_i,
  input  wire logic                                           app_running_i,
  output logic                                                dl_rx_valid_o,
  output logic      [7:0]                                     dl_rx_data_o,
  input  wire logic                                           dl_tx_valid_i,
  input  wire logic [7:0]                                     dl_tx_data_i,
  output logic                                                dl_tx_ready_o,
  output logic                                                module_reset_o
);
  import dsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    dsp_ser_t [NUM_PORTS-1:0]                  ser;
    logic [NUM_PORTS-1:0][BUF_DEPTH-1:0][7:0] mem;
    logic [NUM_PORTS-1:0][BUF_AW-1:0]         wr_ptr;
    logic [NUM_PORTS-1:0][BUF_AW-1:0]         rd_ptr;
    logic [NUM_PORTS-1:0][BUF_AW:0]           level;
    logic [NUM_PORTS-1:0]                     overrun;
    logic [NUM_PORTS-1:0]                     frame_err;
    logic                                     dl_valid;
    logic [7:0]                               dl_data;
    logic [1:0]                               pin_sync;
    logic [7:0]                               low_cnt;
    logic                                     pin_rst;
  } dsp_dev_state_t;

  dsp_dev_state_t                         state_reg;
  dsp_dev_state_t                         state_next;
  logic [NUM_PORTS-1:0]                   rx_pin;
  logic [NUM_PORTS-1:0]                   tx_idle;
  logic [NUM_PORTS-1:0]                   user_owns;

  ////////////////////////////////////////////////////////////////////////////
  // Line mapping; the reset pin is read only by the pin filter in the next-state logic
  assign rx_pin[0]                    = link.port_zero_receive_line;
  assign rx_pin[1]                    = link.port_one_receive_line;
  assign link.port_zero_transmit_line = state_reg.ser[0].tx_line;
  assign link.port_one_transmit_line  = state_reg.ser[1].tx_line;

  // Per-port user handshakes
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    // Port zero is held by the loader until the application runs
    assign user_owns[p]      = (p != 0) || app_running_i;
    assign tx_idle[p]        = (state_reg.ser[p].tx_st == SER_IDLE) && !state_reg.pin_rst;
    assign tx_ready_o[p]     = tx_idle[p] && user_owns[p];
    assign rx_valid_o[p]     = (state_reg.level[p] != '0);
    assign rx_data_o[p]      = state_reg.mem[p][state_reg.rd_ptr[p]];
    assign rx_overrun_o[p]   = state_reg.overrun[p];
    assign rx_frame_err_o[p] = state_reg.frame_err[p];
  end

  // Loader side of port zero
  assign dl_tx_ready_o  = tx_idle[0] && !app_running_i;
  assign dl_rx_valid_o  = state_reg.dl_valid;
  assign dl_rx_data_o   = state_reg.dl_data;
  assign module_reset_o = state_reg.pin_rst;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic             go;
    logic [7:0]       byte_out;
    logic             pop;
    logic             push;
    logic [BUF_AW:0]  cap;
    logic [BUF_AW:0]  after_pop;
    go         = 1'b0;
    byte_out   = '0;
    pop        = 1'b0;
    push       = 1'b0;
    cap        = CAP_SINGLE;
    after_pop  = '0;
    state_next = state_reg;

    // Reset pin filter: must stay low past the minimum time
    state_next.pin_sync = {state_reg.pin_sync[0], link.module_reset_n};
    if (state_reg.pin_sync[1]) begin
      state_next.low_cnt = '0;
      state_next.pin_rst = 1'b0;
    end else if (state_reg.low_cnt != RESET_MIN_CYC) begin
      state_next.low_cnt = state_reg.low_cnt + 8'h01;
    end else begin
      state_next.pin_rst = 1'b1;
    end

    state_next.dl_valid = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      // Transmit source: user, or loader on port zero before start-up
      if (user_owns[p]) begin
        go       = tx_valid_i[p] && tx_ready_o[p];
        byte_out = tx_data_i[p];
      end else begin
        go       = dl_tx_valid_i && dl_tx_ready_o;
        byte_out = dl_tx_data_i;
      end
      // Each port runs its own engine at its own rate
      state_next.ser[p] = dsp_ser_step(state_reg.ser[p], dsp_clamp_div(baud_div_i[p]),
                                       rx_pin[p], go, byte_out);

      // Buffered mode keeps many bytes, single mode only one
      cap       = buffered_mode_i[p] ? CAP_BUFFERED : CAP_SINGLE;
      pop       = rx_valid_o[p] && rx_ready_i[p];
      after_pop = state_reg.level[p] - {4'h0, pop};
      push      = 1'b0;

      // Clear first so that a new error in the same cycle survives
      if (err_clear_i[p]) begin
        state_next.overrun[p]   = 1'b0;
        state_next.frame_err[p] = 1'b0;
      end
      if (state_reg.ser[p].rx_ferr) begin
        state_next.frame_err[p] = 1'b1;
      end

      if (state_reg.ser[p].rx_done) begin
        if (!user_owns[p]) begin
          // Download bytes bypass the user buffer
          state_next.dl_valid = 1'b1;
          state_next.dl_data  = state_reg.ser[p].rx_byte;
        end else if (after_pop < cap) begin
          push = 1'b1;
        end else begin
          state_next.overrun[p] = 1'b1;                               // Newest byte is dropped
        end
      end

      if (push) begin
        state_next.mem[p][state_reg.wr_ptr[p]] = state_reg.ser[p].rx_byte;
        state_next.wr_ptr[p] = state_reg.wr_ptr[p] + 4'h1;
      end
      if (pop) begin
        state_next.rd_ptr[p] = state_reg.rd_ptr[p] + 4'h1;
      end
      state_next.level[p] = after_pop + {4'h0, push};
    end

    // Pin reset clears engines, pointers, levels, error flags and dl_valid; not the pin filter, buffer or dl_data
    if (state_reg.pin_rst) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        state_next.ser[p]       = SER_INIT;
        state_next.wr_ptr[p]    = '0;
        state_next.rd_ptr[p]    = '0;
        state_next.level[p]     = '0;
        state_next.overrun[p]   = 1'b0;
        state_next.frame_err[p] = 1'b0;
      end
      state_next.dl_valid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; core reset clears the whole state, buffer contents included
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg          <= '0;
      state_reg.ser      <= {SER_INIT, SER_INIT};
      state_reg.pin_sync <= 2'b11;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : dsp_device_end

/* File: rtl/dsp_pkg.sv */
// Shared constants, types and serial engine for the dual serial port link
package dsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned NUM_PORTS     = 2;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned BAUD_MIN      = 300;
  localparam int unsigned BAUD_MAX      = 600_000;
  localparam int unsigned DIV_W         = 17;
  // Clock cycles per bit at the fastest and slowest rates
  localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(CLK_HZ / BAUD_MAX);
  localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / BAUD_MIN);
  localparam logic [2:0]       LAST_BIT = 3'(DATA_BITS - 1);

  // Reset pin: low longer than this resets the device end
  localparam int unsigned RESET_MIN_NS  = 2000;
  localparam logic [7:0]  RESET_MIN_CYC = 8'((RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Host holds the pin low twice as long, covering the synchroniser
  localparam logic [7:0]  RESET_HOLD_CYC = 8'(2 * ((RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS));

  // Background receive buffer
  localparam int unsigned BUF_DEPTH  = 16;
  localparam int unsigned BUF_AW     = 4;
  localparam logic [BUF_AW:0] CAP_BUFFERED = (BUF_AW+1)'(BUF_DEPTH);
  localparam logic [BUF_AW:0] CAP_SINGLE   = 5'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine state
  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_START = 2'b01,
    SER_DATA  = 2'b10,
    SER_STOP  = 2'b11
  } dsp_ser_state_t;

  typedef struct packed {
    dsp_ser_state_t   tx_st;
    logic [DIV_W-1:0] tx_cnt;
    logic [2:0]       tx_bit;
    logic [7:0]       tx_sh;
    logic             tx_line;
    dsp_ser_state_t   rx_st;
    logic [DIV_W-1:0] rx_cnt;
    logic [2:0]       rx_bit;
    logic [7:0]       rx_sh;
    logic [1:0]       rx_sync;
    logic             rx_done;
    logic             rx_ferr;
    logic [7:0]       rx_byte;
  } dsp_ser_t;

  localparam dsp_ser_t SER_INIT = '{tx_st: SER_IDLE, tx_cnt: '0, tx_bit: '0, tx_sh: '0, tx_line: 1'b1,
                                    rx_st: SER_IDLE, rx_cnt: '0, rx_bit: '0, rx_sh: '0, rx_sync: 2'b11,
                                    rx_done: 1'b0, rx_ferr: 1'b0, rx_byte: '0};

  ////////////////////////////////////////////////////////////////////////////
  // Keep the bit period inside the supported rate range
  function automatic logic [DIV_W-1:0] dsp_clamp_div(input logic [DIV_W-1:0] d);
    logic [DIV_W-1:0] r;
    r = d;
    if (d < DIV_MIN) r = DIV_MIN;
    if (d > DIV_MAX) r = DIV_MAX;
    return r;
  endfunction : dsp_clamp_div

  // One clock of transmitter and receiver; go is taken only in idle
  function automatic dsp_ser_t dsp_ser_step(input dsp_ser_t s, input logic [DIV_W-1:0] d,
                                            input logic rx_pin, input logic go, input logic [7:0] data);
    dsp_ser_t n;
    logic     rx_in;
    n         = s;
    rx_in     = s.rx_sync[1];
    n.rx_done = 1'b0;
    n.rx_ferr = 1'b0;
    n.rx_sync = {s.rx_sync[0], rx_pin};
    // Transmit: start low, eight bits LSB first, stop high
    unique case (s.tx_st)
      SER_IDLE: begin
        n.tx_line = 1'b1;
        if (go) begin
          n.tx_st   = SER_START;
          n.tx_sh   = data;
          n.tx_cnt  = d - 17'h0_0001;
          n.tx_line = 1'b0;
        end
      end
      default: begin
        if (s.tx_cnt != '0) begin
          n.tx_cnt = s.tx_cnt - 17'h0_0001;
        end else begin
          n.tx_cnt = d - 17'h0_0001;
          unique case (s.tx_st)
            SER_START: begin
              n.tx_st   = SER_DATA;
              n.tx_bit  = '0;
              n.tx_line = s.tx_sh[0];
            end
            SER_DATA: begin
              if (s.tx_bit == LAST_BIT) begin
                n.tx_st   = SER_STOP;
                n.tx_line = 1'b1;
              end else begin
                n.tx_bit  = s.tx_bit + 3'h1;
                n.tx_sh   = {1'b0, s.tx_sh[7:1]};
                n.tx_line = s.tx_sh[1];
              end
            end
            default: n.tx_st = SER_IDLE;    // One stop bit only
          endcase
        end
      end
    endcase
    // Receive: confirm start at mid-bit, then sample each bit centre
    unique case (s.rx_st)
      SER_IDLE: begin
        if (!rx_in) begin
          n.rx_st  = SER_START;
          n.rx_cnt = {1'b0, d[DIV_W-1:1]};
        end
      end
      default: begin
        if (s.rx_cnt != '0) begin
          n.rx_cnt = s.rx_cnt - 17'h0_0001;
        end else begin
          n.rx_cnt = d - 17'h0_0001;
          unique case (s.rx_st)
            SER_START: begin
              // Glitch shorter than half a bit is dropped
              n.rx_st  = rx_in ? SER_IDLE : SER_DATA;
              n.rx_bit = '0;
            end
            SER_DATA: begin
              n.rx_sh = {rx_in, s.rx_sh[7:1]};
              if (s.rx_bit == LAST_BIT) n.rx_st = SER_STOP;
              else n.rx_bit = s.rx_bit + 3'h1;
            end
            default: begin
              n.rx_st   = SER_IDLE;
              n.rx_byte = s.rx_sh;
              n.rx_done = rx_in;
              n.rx_ferr = !rx_in;
            end
          endcase
        end
      end
    endcase
    return n;
  endfunction : dsp_ser_step

endpackage : dsp_pkg

/* File: rtl/dsp_link_if.sv */
// Serial link between device end and host end: two line pairs and reset
interface dsp_link_if;
  logic port_zero_transmit_line;
  logic port_zero_receive_line;
  logic port_one_transmit_line;
  logic port_one_receive_line;
  logic host_reset_out;
  logic host_reset_oe;
  logic module_reset_n;

  // Open-drain reset wire with pull-up; only the host may pull it low
  assign module_reset_n = host_reset_oe ? host_reset_out : 1'b1;

  modport dev (
    input  port_zero_receive_line,
    input  port_one_receive_line,
    input  module_reset_n,
    output port_zero_transmit_line,
    output port_one_transmit_line
  );

  modport host (
    input  port_zero_transmit_line,
    input  port_one_transmit_line,
    output port_zero_receive_line,
    output port_one_receive_line,
    output host_reset_out,
    output host_reset_oe
  );
endinterface : dsp_link_if

/* File: rtl/dsp_host_end.sv */
// Host end: two serial ports facing the device and an open-drain reset
module dsp_host_end
  import dsp_pkg::*;
(
  input  wire logic                                              core_clk_i,
  input  wire logic                                              rst_i,
  dsp_link_if.host                                               link,
  input  wire logic [dsp_pkg::NUM_PORTS-1:0][dsp_pkg::DIV_W-1:0] baud_div_i,
  input  wire logic [dsp_pkg::NUM_PORTS-1:0]                     tx_valid_i,
  input  wire logic [dsp_pkg::NUM_PORTS-1:0][7:0]                tx_data_i,
  output logic      [dsp_pkg::NUM_PORTS-1:0]                     tx_ready_o,
  output logic      [dsp_pkg::NUM_PORTS-1:0]                     rx_valid_o,
  output logic      [dsp_pkg::NUM_PORTS-1:0][7:0]                rx_data_o,
  output logic      [dsp_pkg::NUM_PORTS-1:0]                     rx_frame_err_o,
  input  wire logic                                              reset_req_i,
  output logic                                                   reset_busy_o
);
  import dsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    dsp_ser_t [NUM_PORTS-1:0] ser;
    logic [7:0]               rst_cnt;
  } dsp_host_state_t;

  dsp_host_state_t      state_reg;
  dsp_host_state_t      state_next;
  logic [NUM_PORTS-1:0] rx_pin;

  // Line mapping: host transmit feeds device receive
  assign rx_pin[0]                   = link.port_zero_transmit_line;
  assign rx_pin[1]                   = link.port_one_transmit_line;
  assign link.port_zero_receive_line = state_reg.ser[0].tx_line;
  assign link.port_one_receive_line  = state_reg.ser[1].tx_line;

  // Open drain: drive low only, release to the pull-up otherwise
  assign link.host_reset_out = 1'b0;
  assign link.host_reset_oe  = (state_reg.rst_cnt != '0);
  assign reset_busy_o        = (state_reg.rst_cnt != '0);

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign tx_ready_o[p]     = (state_reg.ser[p].tx_st == SER_IDLE);
    assign rx_valid_o[p]     = state_reg.ser[p].rx_done;
    assign rx_data_o[p]      = state_reg.ser[p].rx_byte;
    assign rx_frame_err_o[p] = state_reg.ser[p].rx_ferr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_next = state_reg;
    for (int p = 0; p < NUM_PORTS; p++) begin
      state_next.ser[p] = dsp_ser_step(state_reg.ser[p], dsp_clamp_div(baud_div_i[p]), rx_pin[p],
                                       tx_valid_i[p] && tx_ready_o[p], tx_data_i[p]);
    end
    // Hold low well past the minimum so the device filter fires
    if (reset_req_i && state_reg.rst_cnt == '0) begin
      state_next.rst_cnt = RESET_HOLD_CYC;
    end else if (state_reg.rst_cnt != '0) begin
      state_next.rst_cnt = state_reg.rst_cnt - 8'h01;
    end
  end

  // Registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg     <= '0;
      state_reg.ser <= {SER_INIT, SER_INIT};
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : dsp_host_end

/* File: tb/dsp_link_assertions.sv */
// Link checker: serial framing on all four lines and the open-drain reset wire
module dsp_link_assertions #(
  parameter int unsigned DIV0 = 41,
  parameter int unsigned DIV1 = 41
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic port_zero_transmit_line,
  input wire logic port_zero_receive_line,
  input wire logic port_one_transmit_line,
  input wire logic port_one_receive_line,
  input wire logic host_reset_out,
  input wire logic host_reset_oe,
  input wire logic module_reset_n
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Line order: port zero device tx, host tx, then port one likewise
  localparam int unsigned DV [4] = '{DIV0, DIV0, DIV1, DIV1};
  logic [3:0]  ln, ln_q_reg, busy_reg;
  logic [19:0] cnt_reg [4];
  logic [7:0]  oe_cnt_reg;
  assign ln = {port_one_receive_line, port_one_transmit_line, port_zero_receive_line, port_zero_transmit_line};

  // Frame opens on a fall outside a frame; closes after ten bit cells
  always_ff @(posedge core_clk_i) begin
    ln_q_reg <= ln;
    for (int i = 0; i < 4; i++) begin
      if (rst_i || (busy_reg[i] && cnt_reg[i] == 20'(10 * DV[i] - 1))) begin
        busy_reg[i] <= 1'b0;
      end else if (!busy_reg[i] && ln_q_reg[i] && !ln[i]) begin
        busy_reg[i] <= 1'b1;
      end
      cnt_reg[i] <= busy_reg[i] ? cnt_reg[i] + 20'h0_0001 : 20'h0_0001;
    end
  end

  // Length of the current reset drive, read at its falling edge
  always_ff @(posedge core_clk_i) begin
    oe_cnt_reg <= (rst_i || !host_reset_oe) ? 8'h00 : oe_cnt_reg + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < 4; g++) begin : g_line
    property p_start_low;
      $fell(ln[g]) && !busy_reg[g] |=> !ln[g] [*8];
    endproperty
    a_start_low: assert property (p_start_low) else $error("Start bit not held low");
    property p_start_cell;
      busy_reg[g] && cnt_reg[g] < 20'(DV[g]) |-> !ln[g];
    endproperty
    a_start_cell: assert property (p_start_cell) else $error("Start cell shorter than a bit");
    property p_bit_cells;
      busy_reg[g] && (cnt_reg[g] % DV[g]) != 0 |-> $stable(ln[g]);
    endproperty
    a_bit_cells: assert property (p_bit_cells) else $error("Line moved inside a bit cell");
    property p_stop_high;
      busy_reg[g] && cnt_reg[g] >= 20'(9 * DV[g]) |-> ln[g];
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("Stop cell not high");
  end

  property p_reset_drive;
    host_reset_oe |-> !host_reset_out && !module_reset_n;
  endproperty
  a_reset_drive: assert property (p_reset_drive) else $error("Reset drive not low");
  property p_reset_owner;
    !module_reset_n |-> host_reset_oe;
  endproperty
  a_reset_owner: assert property (p_reset_owner) else $error("Reset wire low without host");
  property p_reset_len;
    $fell(host_reset_oe) |-> oe_cnt_reg > 8'h32;
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("Reset pulse too short");
  property p_reset_hold;
    $rose(host_reset_oe) |=> host_reset_oe [*8];
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("Reset drive dropped early");
endmodule : dsp_link_assertions

/* File: tb/test_dual_async_serial_ports.sv */
// Testbench: device end and host end joined over the serial link
module test_dual_async_serial_ports
  import dsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Port one runs slower, so the two rates differ
  localparam int unsigned D0 = 41;
  localparam int unsigned D1 = 53;
  logic                  core_clk_i, rst_i, app_run, dl_rx_valid, dl_tx_valid, dl_tx_ready, mrst, h_rst_req, h_busy;
  logic [1:0]            d_tx_valid, d_tx_ready, d_rx_valid, d_rx_ready, d_ovr, d_ferr, d_clr, buf_mode;
  logic [1:0]            h_tx_valid, h_tx_ready, h_rx_valid, h_ferr;
  logic [1:0][7:0]       d_tx_data, d_rx_data, h_tx_data, h_rx_data;
  logic [7:0]            dl_rx_data, dl_tx_data;
  logic [1:0][DIV_W-1:0] div;
  int                    miscompares, check_count, cycles;
  // Row: sender is device, port, byte; the other end receives
  logic [9:0]            rows [6] = '{10'h000, 10'h1FF, 10'h2A5, 10'h301, 10'h280, 10'h15A};

  dsp_link_if dsp_link_if_inst ();
  dsp_device_end dsp_device_end_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(dsp_link_if_inst),
    .baud_div_i(div), .buffered_mode_i(buf_mode), .tx_valid_i(d_tx_valid), .tx_data_i(d_tx_data),
    .tx_ready_o(d_tx_ready), .rx_valid_o(d_rx_valid), .rx_data_o(d_rx_data), .rx_ready_i(d_rx_ready),
    .rx_overrun_o(d_ovr), .rx_frame_err_o(d_ferr), .err_clear_i(d_clr), .app_running_i(app_run),
    .dl_rx_valid_o(dl_rx_valid), .dl_rx_data_o(dl_rx_data), .dl_tx_valid_i(dl_tx_valid),
    .dl_tx_data_i(dl_tx_data), .dl_tx_ready_o(dl_tx_ready), .module_reset_o(mrst));
  dsp_host_end dsp_host_end_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(dsp_link_if_inst),
    .baud_div_i(div), .tx_valid_i(h_tx_valid), .tx_data_i(h_tx_data), .tx_ready_o(h_tx_ready),
    .rx_valid_o(h_rx_valid), .rx_data_o(h_rx_data), .rx_frame_err_o(h_ferr), .reset_req_i(h_rst_req),
    .reset_busy_o(h_busy));
  dsp_link_assertions #(.DIV0(D0), .DIV1(D1)) dsp_link_assertions_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .port_zero_transmit_line(dsp_link_if_inst.port_zero_transmit_line),
    .port_zero_receive_line(dsp_link_if_inst.port_zero_receive_line),
    .port_one_transmit_line(dsp_link_if_inst.port_one_transmit_line),
    .port_one_receive_line(dsp_link_if_inst.port_one_receive_line),
    .host_reset_out(dsp_link_if_inst.host_reset_out), .host_reset_oe(dsp_link_if_inst.host_reset_oe),
    .module_reset_n(dsp_link_if_inst.module_reset_n));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, and a hang guard well above the expected run
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      $display("Error timeout after %0d cycles", cycles);
      results();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Sender 0 host, 1 device, 2 loader; valid held until ready seen
  task automatic send(input int s, input int p, input logic [7:0] d);
    int n = 0;
    @(posedge core_clk_i);
    if (s == 0) begin
      h_tx_data[p] <= d;
      h_tx_valid[p] <= 1'b1;
    end else if (s == 1) begin
      d_tx_data[p] <= d;
      d_tx_valid[p] <= 1'b1;
    end else begin
      dl_tx_data <= d;
      dl_tx_valid <= 1'b1;
    end
    do begin
      @(negedge core_clk_i);
      n++;
    end while ((s == 0 ? h_tx_ready[p] : s == 1 ? d_tx_ready[p] : dl_tx_ready) !== 1'b1 && n < 2000);
    chk("tx_ready", 1'b1, n < 2000);
    @(posedge core_clk_i);
    if (s == 0) h_tx_valid[p] <= 1'b0;
    if (s == 1) d_tx_valid[p] <= 1'b0;
    if (s == 2) dl_tx_valid <= 1'b0;
  endtask : send

  // Receiver 0 host, 1 device (popped after the check), 2 loader
  task automatic get(input int s, input int p, input logic [7:0] e);
    int   n = 0;
    logic v;
    do begin
      @(negedge core_clk_i);
      n++;
      v = s == 0 ? h_rx_valid[p] : s == 1 ? d_rx_valid[p] : dl_rx_valid;
    end while (v !== 1'b1 && n < 3000);
    chk("rx_valid", 1'b1, v);
    chk("rx_data", e, s == 0 ? h_rx_data[p] : s == 1 ? d_rx_data[p] : dl_rx_data);
    if (s == 1) begin
      @(posedge core_clk_i);
      d_rx_ready[p] <= 1'b1;
      @(posedge core_clk_i);
      d_rx_ready[p] <= 1'b0;
    end
  endtask : get

  task automatic results();
    $display("Checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    rst_i = 1'b1;
    app_run = 1'b1;
    buf_mode = 2'b10;
    div = {17'(D1), 17'(D0)};
    {d_tx_valid, d_tx_data, d_rx_ready, d_clr, h_tx_valid, h_tx_data, h_rst_req, dl_tx_valid, dl_tx_data} = '0;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    // Table rows, both directions on both ports
    foreach (rows[i]) begin
      send(int'(rows[i][9]), int'(rows[i][8]), rows[i][7:0]);
      get(1 - int'(rows[i][9]), int'(rows[i][8]), rows[i][7:0]);
    end
    $display("Test rows done");
    // Single mode keeps the first byte; the second one overruns
    send(0, 0, 8'h11);
    send(0, 0, 8'h22);
    repeat (500) @(negedge core_clk_i);
    chk("overrun0", 1'b1, d_ovr[0]);
    get(1, 0, 8'h11);
    @(negedge core_clk_i);
    chk("rx_valid0", 1'b0, d_rx_valid[0]);
    @(posedge core_clk_i);
    d_clr[0] <= 1'b1;
    @(posedge core_clk_i);
    d_clr[0] <= 1'b0;
    @(negedge core_clk_i);
    chk("overrun0", 1'b0, d_ovr[0]);
    chk("frame_err", 8'h00, {h_ferr, d_ferr});
    $display("Test overrun done");
    // Buffered port one fills in the background while it also transmits
    fork
      begin
        send(0, 1, 8'hC1);
        send(0, 1, 8'hC2);
        send(0, 1, 8'hC3);
      end
      begin
        send(1, 1, 8'h3E);
        get(0, 1, 8'h3E);
      end
    join
    repeat (600) @(negedge core_clk_i);
    chk("overrun1", 1'b0, d_ovr[1]);
    get(1, 1, 8'hC1);
    get(1, 1, 8'hC2);
    get(1, 1, 8'hC3);
    @(negedge core_clk_i);
    chk("rx_valid1", 1'b0, d_rx_valid[1]);
    $display("Test buffered done");
    // Port zero belongs to the loader until the application runs
    @(posedge core_clk_i);
    app_run <= 1'b0;
    @(negedge core_clk_i);
    chk("tx_ready0", 1'b0, d_tx_ready[0]);
    send(0, 0, 8'h3C);
    get(2, 0, 8'h3C);
    chk("rx_valid0", 1'b0, d_rx_valid[0]);
    send(2, 0, 8'hC3);
    get(0, 0, 8'hC3);
    @(posedge core_clk_i);
    app_run <= 1'b1;
    $display("Test loader done");
    // Pin reset only after the low time passes the minimum
    @(posedge core_clk_i);
    h_rst_req <= 1'b1;
    @(posedge core_clk_i);
    h_rst_req <= 1'b0;
    repeat (40) @(negedge core_clk_i);
    chk("module_reset", 1'b0, mrst);
    n = 0;
    while (mrst !== 1'b1 && n < 40) begin
      @(negedge core_clk_i);
      n++;
    end
    chk("module_reset", 1'b1, mrst);
    chk("tx_ready", 8'h00, d_tx_ready);
    n = 0;
    while (mrst !== 1'b0 && n < 200) begin
      @(negedge core_clk_i);
      n++;
    end
    chk("reset_busy", 1'b0, h_busy);
    $display("Test pin reset done");
    // Core reset in mid-frame returns every idle value
    @(posedge core_clk_i);
    h_tx_valid[0] <= 1'b1;
    @(posedge core_clk_i);
    h_tx_valid[0] <= 1'b0;
    repeat (100) @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(negedge core_clk_i);
    chk("rx_line0", 1'b1, dsp_link_if_inst.port_zero_receive_line);
    chk("h_tx_ready", 8'h03, h_tx_ready);
    chk("d_tx_ready", 8'h03, d_tx_ready);
    chk("d_rx_valid", 8'h00, d_rx_valid);
    $display("Test reset done");
    results();
  end
endmodule : test_dual_async_serial_ports
